/* verilog/fbs_host.sv */
// Purpose: host sequencer for unlock bypass, program suspend/resume,
//          accelerated program and write status polling of a NOR flash
// Assumes: flash pins sampled synchronously; one command at a time
// Notes:   completion is found by toggle bit, then a fresh full-word read
// Function
// - suspend is one write of 00B0h to an address in the bank
// - resume is one write of 0030h; programming then continues
// - accelerated program used at most 10 times on any sector
// - abort reset inside bypass uses the full three-cycle sequence
// - sectors unlocked before high voltage; high voltage only for acceleration
// - bypass entry: AAh at 555h, 55h at 2AAh, 20h at 555h
// - bypass program: A0h anywhere, then data at target address
// - bypass exit: 90h with bank address, then 00h anywhere
// - polling bit may lead; full word taken on a following read
`timescale 1ns/100ps
`default_nettype none
`include "fbs_defines.svh"

module fbs_host #(
   parameter int ADDR_W = 24,
   parameter int SECT_W = 4,
   parameter int POLL_LIMIT = `FBS_POLL_LIMIT
) (
   input wire logic i_sys_clk,                 // system clock
   input wire logic i_sys_rst,                 // async reset, high
   input wire logic i_cmd_valid,               // command request
   input wire fbs_pkg::fbs_cmd_type i_cmd,     // command code
   input wire logic [ADDR_W-1:0] i_addr,       // target or bank address
   input wire logic [15:0] i_wdata,            // program data
   input wire logic i_sectors_unlocked,        // user vouches sectors unlocked
   output logic o_cmd_ready,                   // idle, takes a command
   output logic o_done,                        // command finished, pulse
   output logic o_error,                       // refused or failed, with done
   output logic [15:0] o_rdata,                // last read word
   output logic o_in_bypass,                   // device in unlock bypass
   output logic o_acc_high,                    // request high voltage on accel pin
   output logic [ADDR_W-1:0] o_flash_addr,     // flash address pins
   output logic [15:0] o_flash_dq_out,         // flash data out
   output logic o_flash_dq_oe_n,               // low while driving data
   input wire logic [15:0] i_flash_dq_in,      // flash data in
   output logic o_flash_ce_n,                  // chip enable, low
   output logic o_flash_oe_n,                  // output enable, low
   output logic o_flash_we_n                   // write strobe, low
);
   import fbs_pkg::*;

   typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT_WR, ST_WAIT, ST_POLL, ST_POLL_WAIT,
                 ST_FINAL, ST_FINAL_WAIT, ST_FINISH} fbs_state_type;

   localparam int NUM_SECT = 1 << SECT_W;
   localparam logic [15:0] SUSP_C = 16'(`FBS_SUSP_LAT_CYC);
   localparam logic [15:0] ACC_C = 16'(`FBS_ACC_SETTLE_CYC);

   fbs_state_type st_reg;
   fbs_cmd_type cmd_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [1:0] step_reg;
   logic [15:0] wait_reg;
   logic [31:0] poll_cnt_reg;
   logic first_reg;
   logic tog_reg;
   logic fail_reg;
   logic suspended_reg;
   logic [3:0] acc_use_reg [NUM_SECT];

   // bus cycle handshake
   logic bc_start_reg;
   logic bc_write_reg;
   logic [ADDR_W-1:0] bc_addr_reg;
   logic [15:0] bc_wdata_reg;
   logic bc_done;
   logic [15:0] bc_rdata;

   // command table lookup: address and data of the current write step
   wire [ADDR_W-1:0] base_u1 = {addr_reg[ADDR_W-1:`FBS_OFS_W], `FBS_OFS_UNLOCK1};
   wire [ADDR_W-1:0] base_u2 = {addr_reg[ADDR_W-1:`FBS_OFS_W], `FBS_OFS_UNLOCK2};
   wire [ADDR_W-1:0] base_0 = {addr_reg[ADDR_W-1:`FBS_OFS_W], `FBS_OFS_W'(0)};
   wire is_prog = (cmd_reg == FBS_CMD_BYP_PROGRAM) || (cmd_reg == FBS_CMD_ACC_PROGRAM);
   wire is_exit = (cmd_reg == FBS_CMD_BYP_EXIT);
   wire is_unlock3 = (cmd_reg == FBS_CMD_BYP_ENTRY) || (cmd_reg == FBS_CMD_ABORT_RESET);
   wire step0 = (step_reg == 2'h0);
   wire step1 = (step_reg == 2'h1);
   wire tab_last = is_unlock3 ? (step_reg == 2'h2) : (is_prog || is_exit) ? step1 : 1'b1;
   wire [15:0] u3_data = step0 ? `FBS_D_UNLOCK1 : step1 ? `FBS_D_UNLOCK2 :
      (cmd_reg == FBS_CMD_BYP_ENTRY) ? `FBS_D_BYP_ENTRY : `FBS_D_ABORT_RST;
   wire [15:0] tab_data = is_unlock3 ? u3_data : is_exit ? (step0 ? `FBS_D_BYP_EXIT1 : `FBS_D_BYP_EXIT2) :
      (cmd_reg == FBS_CMD_SUSPEND) ? `FBS_D_SUSPEND :
      (cmd_reg == FBS_CMD_RESUME) ? `FBS_D_RESUME :
      is_prog ? (step0 ? `FBS_D_BYP_PROG : wdata_reg) : 16'h0000;
   wire [ADDR_W-1:0] tab_addr = is_unlock3 ? (step1 ? base_u2 : base_u1) : is_exit ? (step0 ? addr_reg : base_0) :
      (is_prog && !step0) ? addr_reg : base_0;

   // admission of a new command; bypass gates what may be sent
   wire [SECT_W-1:0] sect_idx = i_addr[ADDR_W-1 -: SECT_W];
   wire acc_ok = i_sectors_unlocked && (acc_use_reg[sect_idx] < `FBS_ACC_LIMIT);
   wire cmd_legal = (i_cmd == FBS_CMD_BYP_ENTRY) ? ~o_in_bypass :
      (i_cmd == FBS_CMD_BYP_PROGRAM || i_cmd == FBS_CMD_BYP_EXIT) ? o_in_bypass & ~suspended_reg :
      (i_cmd == FBS_CMD_ACC_PROGRAM) ? acc_ok & ~o_in_bypass & ~suspended_reg :
      (i_cmd == FBS_CMD_SUSPEND) ? ~suspended_reg :
      (i_cmd == FBS_CMD_RESUME) ? suspended_reg : 1'b1;
   wire take = (st_reg == ST_IDLE) && i_cmd_valid;
   wire needs_poll = is_prog || (cmd_reg == FBS_CMD_RESUME);
   wire tog_now = bc_rdata[`FBS_TOGGLE_BIT];
   wire poll_over = (poll_cnt_reg >= 32'(POLL_LIMIT));
   // program still busy while polling bit shows inverse of written bit
   wire dq7_busy = is_prog && (bc_rdata[`FBS_POLL_BIT] != wdata_reg[`FBS_POLL_BIT]);

   // main sequencer
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_reg <= ST_IDLE;
         cmd_reg <= FBS_CMD_READ;
         addr_reg <= '0;
         wdata_reg <= 16'h0000;
         step_reg <= 2'h0;
         wait_reg <= 16'h0000;
         poll_cnt_reg <= 32'h0000_0000;
         first_reg <= 1'b0;
         tog_reg <= 1'b0;
         fail_reg <= 1'b0;
         bc_start_reg <= 1'b0;
         bc_write_reg <= 1'b0;
         bc_addr_reg <= '0;
         bc_wdata_reg <= 16'h0000;
         o_done <= 1'b0;
         o_error <= 1'b0;
         o_rdata <= 16'h0000;
      end else begin
         bc_start_reg <= 1'b0;
         o_done <= 1'b0;
         o_error <= 1'b0;
         case (st_reg)
            ST_IDLE: if (take) begin
               cmd_reg <= i_cmd;
               addr_reg <= i_addr;
               wdata_reg <= i_wdata;
               step_reg <= 2'h0;
               fail_reg <= 1'b0;
               poll_cnt_reg <= 32'h0000_0000;
               if (!cmd_legal) begin
                  o_done <= 1'b1;
                  o_error <= 1'b1;
               end else if (i_cmd == FBS_CMD_READ) begin
                  st_reg <= ST_FINAL;
               end else if (i_cmd == FBS_CMD_ACC_PROGRAM) begin
                  // device enters bypass itself once the voltage settles
                  wait_reg <= ACC_C;
                  st_reg <= ST_WAIT;
               end else begin
                  st_reg <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               bc_start_reg <= 1'b1;
               bc_write_reg <= 1'b1;
               bc_addr_reg <= tab_addr;
               bc_wdata_reg <= tab_data;
               st_reg <= ST_WAIT_WR;
            end
            ST_WAIT_WR: if (bc_done) begin
               step_reg <= step_reg + 2'h1;
               if (!tab_last) begin
                  st_reg <= ST_ISSUE;
               end else if (cmd_reg == FBS_CMD_SUSPEND) begin
                  wait_reg <= SUSP_C;
                  st_reg <= ST_WAIT;
               end else if (needs_poll) begin
                  first_reg <= 1'b1;
                  st_reg <= ST_POLL;
               end else begin
                  st_reg <= ST_FINISH;
               end
            end
            ST_WAIT: begin
               wait_reg <= wait_reg - 16'h0001;
               if (wait_reg == 16'h0001) begin
                  st_reg <= (cmd_reg == FBS_CMD_ACC_PROGRAM) ? ST_ISSUE : ST_FINISH;
               end
            end
            ST_POLL: begin
               // status read at the command address: the word written for programs, the given address for resume
               bc_start_reg <= 1'b1;
               bc_write_reg <= 1'b0;
               bc_addr_reg <= addr_reg;
               st_reg <= ST_POLL_WAIT;
            end
            ST_POLL_WAIT: if (bc_done) begin
               tog_reg <= tog_now;
               first_reg <= 1'b0;
               poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
               if (!first_reg && (tog_now == tog_reg)) begin
                  // toggle stopped: done, protected, or all-protected
                  st_reg <= ST_FINAL;
               end else if (poll_over) begin
                  fail_reg <= 1'b1;
                  st_reg <= ST_FINISH;
               end else begin
                  st_reg <= ST_POLL;
               end
            end
            ST_FINAL: begin
               // fresh read: polling bit may have led the low bits
               bc_start_reg <= 1'b1;
               bc_write_reg <= 1'b0;
               bc_addr_reg <= addr_reg;
               st_reg <= ST_FINAL_WAIT;
            end
            ST_FINAL_WAIT: if (bc_done) begin
               o_rdata <= bc_rdata;
               // protected sector leaves old data: reported as failure
               if (dq7_busy || (is_prog && (bc_rdata != wdata_reg))) begin
                  fail_reg <= 1'b1;
               end
               st_reg <= ST_FINISH;
            end
            ST_FINISH: begin
               o_done <= 1'b1;
               o_error <= fail_reg;
               st_reg <= ST_IDLE;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // mode flags: bypass survives programs until the exit pair
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_in_bypass <= 1'b0;
         suspended_reg <= 1'b0;
         o_acc_high <= 1'b0;
         o_cmd_ready <= 1'b0;
      end else begin
         o_cmd_ready <= (st_reg == ST_IDLE) && !take;
         if (take && cmd_legal && (i_cmd == FBS_CMD_ACC_PROGRAM)) begin
            o_acc_high <= 1'b1;
         end else if (st_reg == ST_FINISH) begin
            o_acc_high <= 1'b0;
         end
         if (st_reg == ST_FINISH && !fail_reg) begin
            if (cmd_reg == FBS_CMD_BYP_ENTRY) begin
               o_in_bypass <= 1'b1;
            end else if (cmd_reg == FBS_CMD_BYP_EXIT) begin
               o_in_bypass <= 1'b0;
            end
         end
         if (st_reg == ST_FINISH && cmd_reg == FBS_CMD_SUSPEND) begin
            suspended_reg <= 1'b1;
         end else if (st_reg == ST_WAIT_WR && bc_done && cmd_reg == FBS_CMD_RESUME) begin
            suspended_reg <= 1'b0;
         end
      end
   end

   // per-sector count of accelerated uses
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int i = 0; i < NUM_SECT; i++) begin
            acc_use_reg[i] <= 4'h0;
         end
      end else if (take && cmd_legal && (i_cmd == FBS_CMD_ACC_PROGRAM)) begin
         acc_use_reg[sect_idx] <= acc_use_reg[sect_idx] + 4'h1;
      end
   end

   fbs_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(bc_start_reg),
      .i_write(bc_write_reg),
      .i_addr(bc_addr_reg),
      .i_wdata(bc_wdata_reg),
      .o_done(bc_done),
      .o_rdata(bc_rdata),
      .o_flash_addr(o_flash_addr),
      .o_flash_dq_out(o_flash_dq_out),
      .o_flash_dq_oe_n(o_flash_dq_oe_n),
      .i_flash_dq_in(i_flash_dq_in),
      .o_flash_ce_n(o_flash_ce_n),
      .o_flash_oe_n(o_flash_oe_n),
      .o_flash_we_n(o_flash_we_n)
   );
endmodule // fbs_host
`default_nettype wire

/* verilog/fbs_defines.svh */
// Purpose: constants of the flash bypass/suspend host controller
// Assumes: 250 MHz system clock, word-wide flash bus
// Notes:   times in ns, cycle counts derived from them
`ifndef FBS_DEFINES_SVH
`define FBS_DEFINES_SVH

`define FBS_CLK_PS 4000
// command cycle word offsets
`define FBS_OFS_UNLOCK1 12'h555
`define FBS_OFS_UNLOCK2 12'h2aa
`define FBS_OFS_W 12
// command data words
`define FBS_D_UNLOCK1 16'h00aa
`define FBS_D_UNLOCK2 16'h0055
`define FBS_D_BYP_ENTRY 16'h0020
`define FBS_D_BYP_PROG 16'h00a0
`define FBS_D_BYP_EXIT1 16'h0090
`define FBS_D_BYP_EXIT2 16'h0000
`define FBS_D_SUSPEND 16'h00b0
`define FBS_D_RESUME 16'h0030
`define FBS_D_ABORT_RST 16'h00f0
// status bit positions
`define FBS_POLL_BIT 7
`define FBS_TOGGLE_BIT 6
// accelerated use limit per sector
`define FBS_ACC_LIMIT 4'ha
// bus cycle timing, least times round up
`define FBS_T_SETUP_NS 10
`define FBS_T_STROBE_NS 40
`define FBS_T_RECOVER_NS 20
`define FBS_SETUP_CYC ((`FBS_T_SETUP_NS * 1000 + `FBS_CLK_PS - 1) / `FBS_CLK_PS)
`define FBS_STROBE_CYC ((`FBS_T_STROBE_NS * 1000 + `FBS_CLK_PS - 1) / `FBS_CLK_PS)
`define FBS_RECOVER_CYC ((`FBS_T_RECOVER_NS * 1000 + `FBS_CLK_PS - 1) / `FBS_CLK_PS)
// program suspend latency and accelerate settle time
`define FBS_T_SUSP_LAT_NS 5000
`define FBS_SUSP_LAT_CYC ((`FBS_T_SUSP_LAT_NS * 1000 + `FBS_CLK_PS - 1) / `FBS_CLK_PS)
`define FBS_T_ACC_SETTLE_NS 1000
`define FBS_ACC_SETTLE_CYC ((`FBS_T_ACC_SETTLE_NS * 1000 + `FBS_CLK_PS - 1) / `FBS_CLK_PS)
// poll attempts before the operation is declared failed
`define FBS_POLL_LIMIT 20000

`endif

/* verilog/fbs_pkg.sv */
// Purpose: types of the flash bypass/suspend host controller
// Assumes: nothing beyond the defines header
// Notes:   command codes are internal to this controller
package fbs_pkg;
   typedef enum logic [2:0] {
      FBS_CMD_READ,
      FBS_CMD_BYP_ENTRY,
      FBS_CMD_BYP_PROGRAM,
      FBS_CMD_BYP_EXIT,
      FBS_CMD_SUSPEND,
      FBS_CMD_RESUME,
      FBS_CMD_ABORT_RESET,
      FBS_CMD_ACC_PROGRAM
   } fbs_cmd_type;
endpackage

/* verilog/fbs_bus_cycle.sv */
// Purpose: one asynchronous flash bus cycle, read or write
// Assumes: flash data input synchronous to the clock
// Notes:   all pins come from flip-flops; data is driven only on writes
`timescale 1ns/100ps
`default_nettype none
`include "fbs_defines.svh"

module fbs_bus_cycle #(
   parameter int ADDR_W = 24
) (
   input wire logic i_sys_clk,               // system clock
   input wire logic i_sys_rst,               // async reset, high
   input wire logic i_start,                 // start a cycle, pulse
   input wire logic i_write,                 // 1 write, 0 read
   input wire logic [ADDR_W-1:0] i_addr,     // word address
   input wire logic [15:0] i_wdata,          // write data
   output logic o_done,                      // cycle finished, pulse
   output logic [15:0] o_rdata,              // sampled read data
   output logic [ADDR_W-1:0] o_flash_addr,   // flash address pins
   output logic [15:0] o_flash_dq_out,       // flash data out
   output logic o_flash_dq_oe_n,             // low while driving data
   input wire logic [15:0] i_flash_dq_in,    // flash data in
   output logic o_flash_ce_n,                // chip enable, low
   output logic o_flash_oe_n,                // output enable, low
   output logic o_flash_we_n                 // write strobe, low
);
   typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_RECOVER} fbs_phase_type;
   localparam logic [7:0] SETUP_C = 8'(`FBS_SETUP_CYC);
   localparam logic [7:0] STROBE_C = 8'(`FBS_STROBE_CYC);
   localparam logic [7:0] RECOVER_C = 8'(`FBS_RECOVER_CYC);

   fbs_phase_type ph_reg;
   logic [7:0] cnt_reg;
   logic wr_reg;
   wire cnt_end = (cnt_reg == 8'h01);

   // phase sequencer; strobe rises before address or data change
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ph_reg <= PH_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= 16'h0000;
         o_flash_addr <= '0;
         o_flash_dq_out <= 16'h0000;
         o_flash_dq_oe_n <= 1'b1;
         o_flash_ce_n <= 1'b1;
         o_flash_oe_n <= 1'b1;
         o_flash_we_n <= 1'b1;
      end else begin
         o_done <= 1'b0;
         cnt_reg <= cnt_reg - 8'h01;
         case (ph_reg)
            PH_IDLE: begin
               cnt_reg <= SETUP_C;
               if (i_start) begin
                  ph_reg <= PH_SETUP;
                  wr_reg <= i_write;
                  o_flash_addr <= i_addr;
                  o_flash_dq_out <= i_wdata;
                  o_flash_dq_oe_n <= ~i_write;
                  o_flash_ce_n <= 1'b0;
               end
            end
            PH_SETUP: if (cnt_end) begin
               ph_reg <= PH_STROBE;
               cnt_reg <= STROBE_C;
               o_flash_we_n <= ~wr_reg;
               o_flash_oe_n <= wr_reg;
            end
            PH_STROBE: if (cnt_end) begin
               // rising strobe ends the cycle; status is valid from here
               ph_reg <= PH_RECOVER;
               cnt_reg <= RECOVER_C;
               o_rdata <= i_flash_dq_in;
               o_flash_we_n <= 1'b1;
               o_flash_oe_n <= 1'b1;
            end
            PH_RECOVER: if (cnt_end) begin
               // ce high between cycles so each read is a fresh one
               ph_reg <= PH_IDLE;
               o_flash_ce_n <= 1'b1;
               o_flash_dq_oe_n <= 1'b1;
               o_done <= 1'b1;
            end
            default: ph_reg <= PH_IDLE;
         endcase
      end
   end
endmodule // fbs_bus_cycle
`default_nettype wire

/* bench/fbs_host_properties.sv */
// Purpose: port-level checks of the flash host sequencer
// Assumes: single clock domain, async high reset
// Notes:   bound to every fbs_host instance
`timescale 1ns/100ps
`default_nettype none
module fbs_host_checker #(parameter int ADDR_W = 24, parameter int SECT_W = 4, parameter int POLL_LIMIT = 20000) (
   input wire logic i_sys_clk, // clock
   input wire logic i_sys_rst, // reset
   input wire logic i_cmd_valid, // request
   input wire fbs_pkg::fbs_cmd_type i_cmd, // command
   input wire logic [ADDR_W-1:0] i_addr, // address
   input wire logic [15:0] i_wdata, // data
   input wire logic i_sectors_unlocked, // unlocked
   input wire logic o_cmd_ready, // idle
   input wire logic o_done, // done pulse
   input wire logic o_error, // error
   input wire logic [15:0] o_rdata, // read word
   input wire logic o_in_bypass, // bypass
   input wire logic o_acc_high, // accel request
   input wire logic [ADDR_W-1:0] o_flash_addr, // flash addr
   input wire logic [15:0] o_flash_dq_out, // data out
   input wire logic o_flash_dq_oe_n, // drive enable
   input wire logic [15:0] i_flash_dq_in, // data in
   input wire logic o_flash_ce_n, // chip enable
   input wire logic o_flash_oe_n, // output enable
   input wire logic o_flash_we_n // write strobe
);
   import fbs_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // strobes never overlap, or the bus would fight
   chk_strobe_excl: assert property (!(!o_flash_we_n && !o_flash_oe_n)) else $error("we and oe low together");
   chk_write_drive: assert property (!o_flash_we_n |-> !o_flash_dq_oe_n && !o_flash_ce_n) else $error("write undriven");
   chk_read_release: assert property (!o_flash_oe_n |-> o_flash_dq_oe_n) else $error("host drives on read");
   chk_strobe_width: assert property ($fell(o_flash_we_n) |->
      !o_flash_we_n [*8] ##1 !o_flash_we_n [*2] ##1 o_flash_we_n) else $error("write strobe width wrong");
   chk_acc_cause: assert property ($rose(o_acc_high) |->
      $past(i_cmd_valid && i_cmd == FBS_CMD_ACC_PROGRAM && i_sectors_unlocked))
      else $error("accel raised without cause");
   // voltage drops at the very edge that raises done
   chk_acc_drop: assert property ($fell(o_acc_high) |-> o_done) else $error("accel dropped off done");
   chk_ready_quiet: assert property (o_cmd_ready |-> o_flash_ce_n && !o_done && !o_acc_high) else $error("busy when ready");
   chk_acc_no_bypass: assert property ($rose(o_acc_high) |-> !o_in_bypass) else $error("accel in bypass");
   chk_bypass_set: assert property ($rose(o_in_bypass) |-> (o_done || $past(o_done)) && !o_error) else $error("bypass set late");
   chk_bypass_clear: assert property ($fell(o_in_bypass) |-> o_done || $past(o_done)) else $error("bypass cleared late");
   chk_error_done: assert property (o_error |-> o_done) else $error("error without done");
   cov_bypass: cover property ($rose(o_in_bypass));
   cov_acc: cover property ($rose(o_acc_high));
   cov_refuse: cover property (o_done && o_error);
endmodule // fbs_host_checker
bind fbs_host fbs_host_checker #(.ADDR_W(ADDR_W), .SECT_W(SECT_W), .POLL_LIMIT(POLL_LIMIT)) u_chk (.*);
`default_nettype wire

/* bench/fbs_flash_model.sv */
// Purpose: behavioural flash device for the host bench
// Assumes: program only; no erase, no protected sectors
// Notes:   busy lasts BUSY_READS status reads
`timescale 1ns/100ps
`default_nettype none
module fbs_flash_model #(parameter int BUSY_READS = 3) (
   input wire logic [23:0] i_addr, // address pins
   input wire logic [15:0] i_dq, // bus level
   input wire logic i_ce_n, // chip enable
   input wire logic i_oe_n, // output enable
   input wire logic i_we_n, // write strobe
   input wire logic i_acc_high, // accel voltage
   output logic [15:0] o_dq // device drive
);
   logic [15:0] mem [int];
   logic [15:0] pdata = 16'h0000, rdv = 16'h0000;
   logic byp = 0, setup = 0, exit1 = 0, susp = 0, tog = 0;
   int busy = 0, step = 0;
   // commands latched at the write strobe's rising edge
   always @(posedge i_we_n) if (!i_ce_n) begin
      if (busy > 0 && i_dq == 16'h00b0) susp = 1;
      else if (susp && i_dq == 16'h0030) susp = 0;
      else if (busy > 0 || susp) ;
      else if (setup) begin
         setup = 0;
         mem[i_addr] = i_dq;
         pdata = i_dq;
         busy = BUSY_READS;
      end else if (byp || i_acc_high) begin
         if (exit1) begin
            exit1 = 0;
            if (i_dq == 16'h0000) byp = 0;
         end else if (i_dq == 16'h00a0) setup = 1;
         else if (i_dq == 16'h0090) exit1 = 1;
      end else begin
         if (step == 2 && i_dq == 16'h0020 && i_addr[11:0] == 12'h555) byp = 1;
         step = (step == 0 && i_dq == 16'h00aa && i_addr[11:0] == 12'h555) ? 1 :
                (step == 1 && i_dq == 16'h0055 && i_addr[11:0] == 12'h2aa) ? 2 : 0;
      end
   end
   // status word while busy and not suspended, array data otherwise
   always @(negedge i_oe_n) begin
      if (busy > 0 && !susp) rdv = {pdata[15:8], ~pdata[7], tog, pdata[5:0]};
      else rdv = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
   end
   always @(posedge i_oe_n) if (!i_ce_n && busy > 0 && !susp) begin
      tog = ~tog;
      busy = busy - 1;
   end
   // released bus shows the inverse so stale data never passes
   assign o_dq = (!i_ce_n && !i_oe_n) ? rdv : ~rdv;
endmodule // fbs_flash_model
`default_nettype wire

/* bench/test_fbs_host.sv */
// Purpose: self-checking bench of the flash host sequencer
// Assumes: device model answers every bus cycle
// Notes:   small poll limit keeps runs short
`timescale 1ns/100ps
`default_nettype none
module test_fbs_host;
   import fbs_pkg::*;
   logic clk = 0, rst = 1, valid = 0, unl = 0, done, err, inbyp, acc, dq_oe_n, ce_n, oe_n, we_n, rdy;
   fbs_cmd_type cmd = FBS_CMD_READ;
   logic [23:0] addr = 24'h0, faddr;
   logic [15:0] wdata = 16'h0, rdata, dq_out, mdq;
   wire [15:0] dq = !dq_oe_n ? dq_out : mdq;
   logic [31:0] seed = 32'hf332;
   logic [15:0] mem [int];
   int acc_cnt [16];
   int bad_count = 0, samples_checked = 0, cyc = 0;
   logic byp = 0, susp = 0;
   initial forever #2 clk = ~clk;
   fbs_host #(.POLL_LIMIT(50)) dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cmd_valid(valid), .i_cmd(cmd), .i_addr(addr),
      .i_wdata(wdata), .i_sectors_unlocked(unl), .o_cmd_ready(rdy), .o_done(done), .o_error(err), .o_rdata(rdata),
      .o_in_bypass(inbyp), .o_acc_high(acc), .o_flash_addr(faddr), .o_flash_dq_out(dq_out),
      .o_flash_dq_oe_n(dq_oe_n), .i_flash_dq_in(dq), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n));
   fbs_flash_model u_flash (.i_addr(faddr), .i_dq(dq), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_acc_high(acc), .o_dq(mdq));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (exp !== got) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one command, predicted from mode flags, then compared
   task automatic do_cmd(input fbs_cmd_type c, input logic [23:0] a, input logic [15:0] d);
      logic e;
      int n;
      e = (c == FBS_CMD_BYP_ENTRY && byp) || ((c == FBS_CMD_BYP_PROGRAM || c == FBS_CMD_BYP_EXIT) && (!byp || susp))
         || (c == FBS_CMD_ACC_PROGRAM && (byp || susp || !unl || acc_cnt[a[23:20]] >= 10))
         || (c == FBS_CMD_SUSPEND && susp) || (c == FBS_CMD_RESUME && !susp);
      valid = 1;
      cmd = c;
      addr = a;
      wdata = d;
      @(negedge clk);
      valid = 0;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) bad_count++;
      if (!e) case (c)
         FBS_CMD_BYP_ENTRY: byp = 1;
         FBS_CMD_BYP_EXIT: byp = 0;
         FBS_CMD_SUSPEND: susp = 1;
         FBS_CMD_RESUME: susp = 0;
         FBS_CMD_ACC_PROGRAM: begin
            acc_cnt[a[23:20]]++;
            mem[a] = d;
         end
         FBS_CMD_BYP_PROGRAM: mem[a] = d;
         default: ;
      endcase
      chk("error", {15'h0, e}, {15'h0, err});
      if (!e && c inside {FBS_CMD_READ, FBS_CMD_BYP_PROGRAM, FBS_CMD_ACC_PROGRAM, FBS_CMD_RESUME})
         chk("rdata", mem.exists(a) ? mem[a] : 16'hffff, rdata);
      @(negedge clk);
      chk("bypass", {15'h0, byp}, {15'h0, inbyp});
      chk("ready", 16'h0001, {15'h0, rdy});
      $display("test %s ended", c.name());
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      logic [23:0] a;
      repeat (16) @(negedge clk);
      rst = 0;
      repeat (2) @(negedge clk);
      do_cmd(FBS_CMD_READ, xs(), 16'h0);
      do_cmd(FBS_CMD_BYP_PROGRAM, xs(), 16'h1234);
      do_cmd(FBS_CMD_ACC_PROGRAM, xs(), 16'h1234);
      do_cmd(FBS_CMD_BYP_ENTRY, 24'h100000, 16'h0);
      do_cmd(FBS_CMD_BYP_ENTRY, 24'h100000, 16'h0);
      repeat (3) do_cmd(FBS_CMD_BYP_PROGRAM, xs(), xs());
      do_cmd(FBS_CMD_ACC_PROGRAM, xs(), 16'h0);
      do_cmd(FBS_CMD_ABORT_RESET, 24'h100000, 16'h0);
      do_cmd(FBS_CMD_BYP_EXIT, 24'h100000, 16'h0);
      do_cmd(FBS_CMD_BYP_EXIT, 24'h100000, 16'h0);
      do_cmd(FBS_CMD_RESUME, 24'h200000, 16'h0);
      do_cmd(FBS_CMD_SUSPEND, 24'h200000, 16'h0);
      do_cmd(FBS_CMD_SUSPEND, 24'h200000, 16'h0);
      do_cmd(FBS_CMD_BYP_PROGRAM, 24'h200010, 16'h5a5a);
      do_cmd(FBS_CMD_READ, 24'h200000, 16'h0);
      do_cmd(FBS_CMD_RESUME, xs(), 16'h0);
      do_cmd(FBS_CMD_RESUME, 24'h200000, 16'h0);
      unl = 1;
      repeat (11) begin
         a = {4'h3, 20'(xs())};
         do_cmd(FBS_CMD_ACC_PROGRAM, a, xs());
      end
      do_cmd(FBS_CMD_READ, a, 16'h0);
      finish_test();
   end
endmodule // test_fbs_host
`default_nettype wire
